/* design/rvm_monitor_top.sv */
// reference period monitors, profiles and validation control of the clock synchronizer
// Summary of operation
// - all references without bypass report faulted until the system clock stability timer expires
// - each reference has its own continuous period monitor against its profile
// - nominal period is an unsigned 40-bit femtosecond value, up to about 1.1 ms
// - inner and outer tolerances are 20-bit reciprocals of fractional deviation
// - faulted reference clears only when deviation is within inner tolerance
// - unfaulted reference faults when deviation exceeds outer tolerance
// - per-reference validation timer in milliseconds, up to 65,535 ms
// - zero validation period disables timer; software then forces the expiry
// - per-reference redetect timer in milliseconds, active under automatic selection only
// - zero redetect timeout disables the redetect timer
// - faulted high holds the valid latch reset, valid low regardless
// - faulted rising resets the validation timer to a full count
// - validation timer counts only while unfaulted, held reset while faulted
// - on validation expiry the valid latch captures inverted faulted
// - with all override controls zero, faulted equals the monitor fault
// - bypass set makes faulted follow the override bit alone
// - with bypass clear, override set forces faulted high
// - writing one to force expiry triggers the valid latch, bit self-clears
// - eight identical profiles, any reference to any profile, sharing allowed
// - profile settings take effect when an assigned reference becomes active
// - each pin pair is one differential or two single-ended receivers
// - a reference without profile assignment is invalid
// - redetect expiry clears the profile assignment to null
`include "rvm_defines.svh"

module rvm_monitor_top #(
	parameter int NUM_REFS = 4,
	parameter int NUM_PROFILES = 8
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic reference_input_zero_i,
	input wire logic reference_input_one_i,
	input wire logic reference_input_two_i,
	input wire logic reference_input_three_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic assign_we_i,
	input wire logic [1:0] assign_ref_i,
	input wire logic [2:0] assign_prof_i,
	input wire logic active_ref_en_i,
	input wire logic [1:0] active_ref_i,
	output logic [7:0] reg_rdata_o,
	output logic [3:0] valid_o,
	output logic [3:0] faulted_o,
	output logic stable_o,
	output logic [2:0] active_prof_o,
	output logic active_prof_valid_o
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	// the register map is laid out for exactly this many of each
	if (NUM_REFS != 4) begin : g_bad_refs
		$error("rvm_monitor_top: NUM_REFS must be 4");
	end
	if (NUM_PROFILES != 8) begin : g_bad_profs
		$error("rvm_monitor_top: NUM_PROFILES must be 8");
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	// |meas - nom| * tol <= nom is the same as deviation <= 1/tol, no divider
	function automatic logic rvm_within(input logic [39:0] meas,
		input logic [39:0] nom, input logic [19:0] tol);
		logic [39:0] dev;
		logic [59:0] prod;
		dev = (meas > nom) ? 40'(meas - nom) : 40'(nom - meas);
		prod = dev * tol;
		return prod <= {20'h00000, nom};
	endfunction : rvm_within

	function automatic logic [39:0] rvm_put_byte(input logic [39:0] f,
		input logic [2:0] idx, input logic [7:0] b);
		logic [39:0] r;
		r = f;
		r[8 * idx +: 8] = b;
		return r;
	endfunction : rvm_put_byte

	function automatic logic [7:0] rvm_get_byte(input logic [39:0] f,
		input logic [2:0] idx);
		return f[8 * idx +: 8];
	endfunction : rvm_get_byte

	// ****************************************************************
	// state
	// ****************************************************************
	rvm_pkg::rvm_top_state_t st_q;
	rvm_pkg::rvm_top_state_t st_d;
	logic [3:0] ref_pins;
	logic [3:0] val_faulted;
	logic [3:0] val_valid;
	logic [3:0] val_redet;
	logic [3:0] redet_en;
	logic [3:0][15:0] val_ms;
	logic [3:0][15:0] redet_ms;

	assign ref_pins = {reference_input_three_i, reference_input_two_i,
		reference_input_one_i, reference_input_zero_i};

	always_comb begin
		for (int r = 0; r < 4; r++) begin
			val_ms[r] = st_q.prof[st_q.asn[r].prof].val_ms;
			redet_ms[r] = st_q.prof[st_q.asn[r].prof].redet_ms;
			redet_en[r] = ~st_q.man_sel[4 * r + `RVM_SEL_MANUAL_BIT]
				& st_q.asn[r].assigned;
		end
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	logic [39:0] acc_sum;
	logic [39:0] nom;
	logic [39:0] meas;
	logic edge_seen;
	logic ignored;
	logic [5:0] poff;
	logic [2:0] pidx;
	logic [2:0] aidx;

	always_comb begin
		st_d = st_q;
		acc_sum = 40'h0;
		nom = 40'h0;
		meas = 40'h0;
		edge_seen = 1'b0;
		ignored = 1'b0;
		poff = reg_addr_i[5:0];
		pidx = reg_addr_i[8:6];
		aidx = 3'h0;

		// pins come from other clock domains: only the second and third stages feed logic
		st_d.s1 = ref_pins;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;

		// fractional-rate accumulator keeps the tick accurate for any period
		acc_sum = 40'(st_q.ms_acc + {16'h0000, st_q.sys_per});
		if (acc_sum >= `RVM_FS_PER_MS) begin
			st_d.ms_tick = 1'b1;
			st_d.ms_acc = 40'(acc_sum - `RVM_FS_PER_MS);
		end else begin
			st_d.ms_tick = 1'b0;
			st_d.ms_acc = acc_sum;
		end

		if (!st_q.stable) begin
			if (st_q.stab_cnt >= st_q.stab_ms) begin
				st_d.stable = 1'b1;
			end else if (st_q.ms_tick) begin
				st_d.stab_cnt = 16'(st_q.stab_cnt + 16'h0001);
			end
		end

		// period monitors, one per reference
		for (int r = 0; r < 4; r++) begin
			edge_seen = st_q.s2[r] & ~st_q.s3[r];
			nom = st_q.prof[st_q.asn[r].prof].period;
			meas = st_q.run_fs[r][40] ? 40'hFFFFFFFFFF : st_q.run_fs[r][39:0];
			// odd reference of a differential pair has no receiver
			ignored = (r % 2 == 1) && st_q.pair_diff[r / 2];
			if (edge_seen) begin
				st_d.run_fs[r] = {17'h00000, st_q.sys_per};
			end else if (!st_q.run_fs[r][40]) begin
				st_d.run_fs[r] = 41'(st_q.run_fs[r] + {17'h00000, st_q.sys_per});
			end
			if (!st_q.stable || !st_q.asn[r].assigned || ignored) begin
				st_d.mon_fault[r] = 1'b1;
			end else if (edge_seen) begin
				if (st_q.mon_fault[r]) begin
					st_d.mon_fault[r] = ~rvm_within(meas, nom,
						st_q.prof[st_q.asn[r].prof].inner);
				end else begin
					st_d.mon_fault[r] = ~rvm_within(meas, nom,
						st_q.prof[st_q.asn[r].prof].outer);
				end
			end else if (st_q.run_fs[r] > {nom, 1'b0}) begin
				// a missing edge cannot wait for the next measurement
				st_d.mon_fault[r] = 1'b1;
			end
		end

		// profile assignment table
		for (int r = 0; r < 4; r++) begin
			if (st_q.man_sel[4 * r + `RVM_SEL_MANUAL_BIT]) begin
				st_d.asn[r].assigned = 1'b1;
				st_d.asn[r].prof = st_q.man_sel[4 * r +: 3];
			end else begin
				if (val_redet[r]) begin
					st_d.asn[r].assigned = 1'b0;
				end
				// a new assignment in the same cycle wins over the clear
				if (assign_we_i && assign_ref_i == 2'(r)) begin
					st_d.asn[r].assigned = 1'b1;
					st_d.asn[r].prof = assign_prof_i;
				end
			end
		end

		// settings of the active reference's profile
		if (active_ref_en_i) begin
			st_d.act_valid = st_q.asn[active_ref_i].assigned;
			st_d.act_prof = st_q.asn[active_ref_i].prof;
		end else begin
			st_d.act_valid = 1'b0;
		end

		// register writes
		st_d.force_exp = 4'h0;
		if (reg_wr_i) begin
			if (reg_addr_i >= `RVM_ADDR_SYSPER && reg_addr_i < `RVM_ADDR_STAB) begin
				st_d.sys_per = 24'(rvm_put_byte({16'h0000, st_q.sys_per},
					3'(reg_addr_i - `RVM_ADDR_SYSPER), reg_wdata_i));
			end
			if (reg_addr_i == `RVM_ADDR_STAB || reg_addr_i == 16'(`RVM_ADDR_STAB + 16'h0001)) begin
				st_d.stab_ms = 16'(rvm_put_byte({24'h000000, st_q.stab_ms},
					3'(reg_addr_i - `RVM_ADDR_STAB), reg_wdata_i));
			end
			if (reg_addr_i == `RVM_ADDR_PAIRCFG) begin
				st_d.pair_diff = reg_wdata_i[1:0];
			end
			if (reg_addr_i == `RVM_ADDR_MANSEL0) begin
				st_d.man_sel[7:0] = reg_wdata_i;
			end
			if (reg_addr_i == `RVM_ADDR_MANSEL1) begin
				st_d.man_sel[15:8] = reg_wdata_i;
			end
			if (reg_addr_i == `RVM_ADDR_FORCE) begin
				st_d.force_exp = reg_wdata_i[3:0];
			end
			if (reg_addr_i == `RVM_ADDR_OVR) begin
				st_d.ovr = reg_wdata_i[3:0];
			end
			if (reg_addr_i == `RVM_ADDR_BYP) begin
				st_d.byp = reg_wdata_i[3:0];
			end
			if (reg_addr_i[15:9] == `RVM_PROF_PAGE) begin
				if (poff >= `RVM_POFF_PER && poff < `RVM_POFF_INNER) begin
					st_d.prof[pidx].period = rvm_put_byte(st_q.prof[pidx].period,
						3'(poff - `RVM_POFF_PER), reg_wdata_i);
				end else if (poff >= `RVM_POFF_INNER && poff < `RVM_POFF_OUTER) begin
					st_d.prof[pidx].inner = 20'(rvm_put_byte({20'h00000,
						st_q.prof[pidx].inner}, 3'(poff - `RVM_POFF_INNER), reg_wdata_i));
				end else if (poff >= `RVM_POFF_OUTER && poff < `RVM_POFF_VAL) begin
					st_d.prof[pidx].outer = 20'(rvm_put_byte({20'h00000,
						st_q.prof[pidx].outer}, 3'(poff - `RVM_POFF_OUTER), reg_wdata_i));
				end else if (poff >= `RVM_POFF_VAL && poff < `RVM_POFF_REDET) begin
					st_d.prof[pidx].val_ms = 16'(rvm_put_byte({24'h000000,
						st_q.prof[pidx].val_ms}, 3'(poff - `RVM_POFF_VAL), reg_wdata_i));
				end else if (poff == `RVM_POFF_REDET || poff == 6'(`RVM_POFF_REDET + 6'h01)) begin
					st_d.prof[pidx].redet_ms = 16'(rvm_put_byte({24'h000000,
						st_q.prof[pidx].redet_ms}, 3'(poff - `RVM_POFF_REDET), reg_wdata_i));
				end
			end
		end

		// register reads; unmapped addresses answer zero
		if (reg_rd_i) begin
			st_d.rdata = 8'h00;
			aidx = 3'(reg_addr_i - `RVM_ADDR_ASN0);
			if (reg_addr_i >= `RVM_ADDR_SYSPER && reg_addr_i < `RVM_ADDR_STAB) begin
				st_d.rdata = rvm_get_byte({16'h0000, st_q.sys_per},
					3'(reg_addr_i - `RVM_ADDR_SYSPER));
			end else if (reg_addr_i == `RVM_ADDR_STAB
				|| reg_addr_i == 16'(`RVM_ADDR_STAB + 16'h0001)) begin
				st_d.rdata = rvm_get_byte({24'h000000, st_q.stab_ms},
					3'(reg_addr_i - `RVM_ADDR_STAB));
			end else if (reg_addr_i == `RVM_ADDR_PAIRCFG) begin
				st_d.rdata = {6'h00, st_q.pair_diff};
			end else if (reg_addr_i == `RVM_ADDR_MANSEL0) begin
				st_d.rdata = st_q.man_sel[7:0];
			end else if (reg_addr_i == `RVM_ADDR_MANSEL1) begin
				st_d.rdata = st_q.man_sel[15:8];
			end else if (reg_addr_i == `RVM_ADDR_OVR) begin
				st_d.rdata = {4'h0, st_q.ovr};
			end else if (reg_addr_i == `RVM_ADDR_BYP) begin
				st_d.rdata = {4'h0, st_q.byp};
			end else if (reg_addr_i == `RVM_ADDR_STATUS) begin
				st_d.rdata = {val_faulted, val_valid};
			end else if (reg_addr_i == `RVM_ADDR_STABLE) begin
				st_d.rdata = {7'h00, st_q.stable};
			end else if (reg_addr_i >= `RVM_ADDR_ASN0 && reg_addr_i <= `RVM_ADDR_ASN3) begin
				st_d.rdata[`RVM_ASN_VALID_BIT] = st_q.asn[aidx[1:0]].assigned;
				st_d.rdata[`RVM_ASN_PROF_LSB +: 3] = st_q.asn[aidx[1:0]].prof;
			end else if (reg_addr_i[15:9] == `RVM_PROF_PAGE) begin
				if (poff >= `RVM_POFF_PER && poff < `RVM_POFF_INNER) begin
					st_d.rdata = rvm_get_byte(st_q.prof[pidx].period,
						3'(poff - `RVM_POFF_PER));
				end else if (poff >= `RVM_POFF_INNER && poff < `RVM_POFF_OUTER) begin
					st_d.rdata = rvm_get_byte({20'h00000, st_q.prof[pidx].inner},
						3'(poff - `RVM_POFF_INNER));
				end else if (poff >= `RVM_POFF_OUTER && poff < `RVM_POFF_VAL) begin
					st_d.rdata = rvm_get_byte({20'h00000, st_q.prof[pidx].outer},
						3'(poff - `RVM_POFF_OUTER));
				end else if (poff >= `RVM_POFF_VAL && poff < `RVM_POFF_REDET) begin
					st_d.rdata = rvm_get_byte({24'h000000, st_q.prof[pidx].val_ms},
						3'(poff - `RVM_POFF_VAL));
				end else if (poff == `RVM_POFF_REDET
					|| poff == 6'(`RVM_POFF_REDET + 6'h01)) begin
					st_d.rdata = rvm_get_byte({24'h000000, st_q.prof[pidx].redet_ms},
						3'(poff - `RVM_POFF_REDET));
				end
			end
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= '0;
			st_q.mon_fault <= 4'hF;
			st_q.sys_per <= `RVM_RST_SYSPER;
			st_q.stab_ms <= `RVM_RST_STAB;
			for (int p = 0; p < 8; p++) begin
				st_q.prof[p] <= '{period: `RVM_RST_PERIOD, inner: `RVM_RST_TOL,
					outer: `RVM_RST_TOL, val_ms: `RVM_RST_TIMER,
					redet_ms: `RVM_RST_TIMER};
			end
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// per-reference validation
	// ****************************************************************
	for (genvar r = 0; r < 4; r++) begin : g_val
		rvm_ref_validate u_val (
			.clk_i(clk_i),
			.reset_n_i(reset_n_i),
			.ce_i(ce_i),
			.ms_tick_i(st_q.ms_tick),
			.mon_fault_i(st_q.mon_fault[r]),
			.bypass_i(st_q.byp[r]),
			.override_i(st_q.ovr[r]),
			.force_i(st_q.force_exp[r]),
			.val_ms_i(val_ms[r]),
			.redet_ms_i(redet_ms[r]),
			.redet_en_i(redet_en[r]),
			.faulted_o(val_faulted[r]),
			.valid_o(val_valid[r]),
			.redetect_o(val_redet[r])
		);
	end

	assign reg_rdata_o = st_q.rdata;
	assign valid_o = val_valid;
	assign faulted_o = val_faulted;
	assign stable_o = st_q.stable;
	assign active_prof_o = st_q.act_prof;
	assign active_prof_valid_o = st_q.act_valid;

endmodule : rvm_monitor_top

/* design/rvm_defines.svh */
// offsets, field positions, reset values and timing counts of the reference monitor
`ifndef RVM_DEFINES_SVH
`define RVM_DEFINES_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define RVM_ADDR_SYSPER 16'h0100
`define RVM_ADDR_STAB 16'h0103
`define RVM_ADDR_PAIRCFG 16'h0500
`define RVM_ADDR_MANSEL0 16'h0503
`define RVM_ADDR_MANSEL1 16'h0504
`define RVM_PROF_PAGE 7'h03
`define RVM_POFF_PER 6'h01
`define RVM_POFF_INNER 6'h06
`define RVM_POFF_OUTER 6'h09
`define RVM_POFF_VAL 6'h0C
`define RVM_POFF_REDET 6'h0E
`define RVM_ADDR_FORCE 16'h0A0E
`define RVM_ADDR_OVR 16'h0A0F
`define RVM_ADDR_BYP 16'h0A10
`define RVM_ADDR_STATUS 16'h0D05
`define RVM_ADDR_STABLE 16'h0D06
`define RVM_ADDR_ASN0 16'h0D0C
`define RVM_ADDR_ASN3 16'h0D0F

// ****************************************************************
// field positions
// ****************************************************************
`define RVM_SEL_MANUAL_BIT 3
`define RVM_ASN_VALID_BIT 7
`define RVM_ASN_PROF_LSB 4

// ****************************************************************
// reset values and timing
// ****************************************************************
`define RVM_RST_SYSPER 24'h4C4B40
`define RVM_RST_STAB 16'h000A
`define RVM_RST_TOL 20'h04E20
`define RVM_RST_PERIOD 40'h00000000
`define RVM_RST_TIMER 16'h0000
`define RVM_FS_PER_MS 40'hE8D4A51000

`endif

/* design/rvm_pkg.sv */
// types shared by the reference monitor modules
package rvm_pkg;

	typedef struct packed {
		logic [39:0] period;
		logic [19:0] inner;
		logic [19:0] outer;
		logic [15:0] val_ms;
		logic [15:0] redet_ms;
	} rvm_prof_t;

	typedef struct packed {
		logic assigned;
		logic [2:0] prof;
	} rvm_asn_t;

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0][40:0] run_fs;
		logic [3:0] mon_fault;
		logic [39:0] ms_acc;
		logic ms_tick;
		logic [15:0] stab_cnt;
		logic stable;
		logic [23:0] sys_per;
		logic [15:0] stab_ms;
		logic [1:0] pair_diff;
		logic [15:0] man_sel;
		rvm_prof_t [7:0] prof;
		rvm_asn_t [3:0] asn;
		logic [3:0] force_exp;
		logic [3:0] ovr;
		logic [3:0] byp;
		logic [7:0] rdata;
		logic [2:0] act_prof;
		logic act_valid;
	} rvm_top_state_t;

	typedef struct packed {
		logic faulted;
		logic valid;
		logic redet;
		logic [15:0] vcnt;
		logic [15:0] rcnt;
	} rvm_val_state_t;

endpackage : rvm_pkg

/* design/rvm_ref_validate.sv */
// validation logic of one reference: fault mux, valid latch, validation and redetect timers
module rvm_ref_validate (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic ms_tick_i,
	input wire logic mon_fault_i,
	input wire logic bypass_i,
	input wire logic override_i,
	input wire logic force_i,
	input wire logic [15:0] val_ms_i,
	input wire logic [15:0] redet_ms_i,
	input wire logic redet_en_i,
	output logic faulted_o,
	output logic valid_o,
	output logic redetect_o
);

	rvm_pkg::rvm_val_state_t st_q;
	rvm_pkg::rvm_val_state_t st_d;
	logic faulted_n;
	logic expire;

	always_comb begin
		st_d = st_q;
		expire = 1'b0;
		st_d.redet = 1'b0;
		// bypass hands the decision to an external monitor
		faulted_n = bypass_i ? override_i : (override_i | mon_fault_i);
		st_d.faulted = faulted_n;
		if (faulted_n) begin
			st_d.vcnt = 16'h0000;
		end else if (val_ms_i != 16'h0000 && ms_tick_i && st_q.vcnt < val_ms_i) begin
			st_d.vcnt = 16'(st_q.vcnt + 16'h0001);
			expire = (16'(st_q.vcnt + 16'h0001) == val_ms_i);
		end
		if (faulted_n) begin
			st_d.valid = 1'b0;
		end else if (expire || force_i) begin
			st_d.valid = ~faulted_n;
		end
		if (redet_en_i && redet_ms_i != 16'h0000 && faulted_n) begin
			if (ms_tick_i) begin
				if (16'(st_q.rcnt + 16'h0001) >= redet_ms_i) begin
					st_d.redet = 1'b1;
					st_d.rcnt = 16'h0000;
				end else begin
					st_d.rcnt = 16'(st_q.rcnt + 16'h0001);
				end
			end
		end else begin
			st_d.rcnt = 16'h0000;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= '{faulted: 1'b1, valid: 1'b0, redet: 1'b0,
				vcnt: 16'h0000, rcnt: 16'h0000};
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end

	assign faulted_o = st_q.faulted;
	assign valid_o = st_q.valid;
	assign redetect_o = st_q.redet;

endmodule : rvm_ref_validate

/* verif/rvm_monitor_chk.sv */
// port assertions of the reference monitor
module rvm_monitor_chk #(
	parameter int NUM_REFS = 4,
	parameter int NUM_PROFILES = 8
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic active_ref_en_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [3:0] valid_o,
	input wire logic [3:0] faulted_o,
	input wire logic stable_o,
	input wire logic active_prof_valid_o
);
	logic [3:0] ovr_q;
	logic [3:0] byp_q;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// ********************
	// shadow of override controls
	// ********************
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ovr_q <= 4'h0;
			byp_q <= 4'h0;
		end else if (ce_i && reg_wr_i) begin
			ovr_q <= (reg_addr_i == 16'h0A0F) ? reg_wdata_i[3:0] : ovr_q;
			byp_q <= (reg_addr_i == 16'h0A10) ? reg_wdata_i[3:0] : byp_q;
		end
	end
	// ********************
	// properties
	// ********************
	property p_unstable;
		!stable_o |-> faulted_o == 4'hF;
	endproperty
	property p_flt_valid;
		(faulted_o & $past(faulted_o) & valid_o) == 4'h0;
	endproperty
	property p_rise;
		(valid_o & ~$past(valid_o) & faulted_o) == 4'h0;
	endproperty
	sequence s_force;
		ce_i && reg_wr_i && reg_addr_i == 16'h0A0E && reg_wdata_i[0] && !faulted_o[0]
		##1 !faulted_o[0] ##1 !faulted_o[0];
	endsequence
	property p_force;
		s_force |-> valid_o[0];
	endproperty
	property p_ovr;
		(faulted_o & $past(ovr_q) & ~$past(byp_q)) == ($past(ovr_q) & ~$past(byp_q));
	endproperty
	property p_byp;
		stable_o && $past(stable_o) |-> ((faulted_o ^ $past(ovr_q)) & $past(byp_q)) == 4'h0;
	endproperty
	property p_rd_hold;
		!$past(reg_rd_i) |-> $stable(reg_rdata_o);
	endproperty
	property p_rd_force;
		ce_i && reg_rd_i && reg_addr_i == 16'h0A0E |=> reg_rdata_o == 8'h00;
	endproperty
	property p_act;
		!active_ref_en_i |=> !active_prof_valid_o;
	endproperty
	a_unstable: assert property (p_unstable) else $error("fault not forced");
	a_flt_valid: assert property (p_flt_valid) else $error("valid with fault");
	a_rise: assert property (p_rise) else $error("valid rose while faulted");
	a_force: assert property (p_force) else $error("forced expiry lost");
	a_ovr: assert property (p_ovr) else $error("override not faulting");
	a_byp: assert property (p_byp) else $error("bypass not following override");
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	a_rd_force: assert property (p_rd_force) else $error("force reg read nonzero");
	a_act: assert property (p_act) else $error("active profile valid w/o ref");
	c_valid: cover property ($rose(valid_o[0]));
	c_clear: cover property ($fell(faulted_o[0]));
	c_stable: cover property ($rose(stable_o));
endmodule : rvm_monitor_chk

bind rvm_monitor_top rvm_monitor_chk #(.NUM_REFS(NUM_REFS), .NUM_PROFILES(NUM_PROFILES)) u_chk (
	.clk_i, .reset_n_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
	.active_ref_en_i, .reg_rdata_o, .valid_o, .faulted_o, .stable_o, .active_prof_valid_o);

/* verif/rvm_ref_src_model.sv */
// four reference clock sources, fast (48 ns) or slow (96 ns) or stopped
module rvm_ref_src_model (
	input wire logic [3:0] run_i,
	input wire logic [3:0] slow_i,
	output wire logic [3:0] ref_o
);
	timeunit 1ns;
	timeprecision 100ps;
	for (genvar g = 0; g < 4; g++) begin : g_src
		logic r;
		assign ref_o[g] = r;
		initial begin
			r = 1'b0;
			#(3 * g + 1);
			forever begin
				// stopped pin rests low like the single-ended pull-down
				r = run_i[g];
				#(slow_i[g] ? 48 : 24);
				r = 1'b0;
				#(slow_i[g] ? 48 : 24);
			end
		end
	end
endmodule : rvm_ref_src_model

/* verif/rvm_monitor_top_tb.sv */
// self-checking bench of the reference monitor
module rvm_monitor_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i, reset_n_i, ce_i, reg_wr_i, reg_rd_i, assign_we_i, active_ref_en_i, stable_o;
	logic active_prof_valid_o;
	logic [15:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o;
	logic [1:0] assign_ref_i, active_ref_i;
	logic [2:0] assign_prof_i, active_prof_o;
	logic [3:0] run, slow, ref_w, valid_o, faulted_o;
	int num_errors = 0;
	int total_checks = 0;
	// profile 0: 48 ns period, inner 1/4, outer 1/2; refs 0,1,3 on profile 0, ref 2 on 1
	logic [23:0] tbl [15] = '{24'h060100, 24'h06026C, 24'h0603DC, 24'h060402, 24'h060500,
		24'h060604, 24'h060700, 24'h060800, 24'h060902, 24'h060A00, 24'h060B00,
		24'h050388, 24'h050489, 24'h010300, 24'h010400};
	rvm_ref_src_model u_src (.run_i(run), .slow_i(slow), .ref_o(ref_w));
	rvm_monitor_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
		.reference_input_zero_i(ref_w[0]), .reference_input_one_i(ref_w[1]),
		.reference_input_two_i(ref_w[2]), .reference_input_three_i(ref_w[3]),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .assign_we_i(assign_we_i), .assign_ref_i(assign_ref_i),
		.assign_prof_i(assign_prof_i), .active_ref_en_i(active_ref_en_i),
		.active_ref_i(active_ref_i), .reg_rdata_o(reg_rdata_o), .valid_o(valid_o),
		.faulted_o(faulted_o), .stable_o(stable_o), .active_prof_o(active_prof_o),
		.active_prof_valid_o(active_prof_valid_o));
	// ********************
	// helpers
	// ********************
	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task idle(input int n);
		repeat (n) @(negedge clk_i);
	endtask : idle
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask : wr
	task rd(input logic [15:0] a, input logic [7:0] exp);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		chk("reg_rdata_o", exp, reg_rdata_o);
	endtask : rd
	// bounded wait; 200 cycles covers several reference periods
	task wait_flt(input int i, input logic e);
		int n;
		n = 0;
		while (faulted_o[i] !== e && n < 200) begin
			@(negedge clk_i);
			n++;
		end
		chk("faulted_o bit", {7'h0, e}, {7'h0, faulted_o[i]});
	endtask : wait_flt
	task end_of_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	// ********************
	// scenarios
	// ********************
	task t_reset;
		idle(40);
		chk("faulted_o", 8'h0F, {4'h0, faulted_o});
		chk("stable_o", 8'h00, {7'h0, stable_o});
		rd(16'h0A0F, 8'h00);
		rd(16'h0A10, 8'h00);
		rd(16'h0D0C, 8'h00);
		rd(16'h1234, 8'h00);
	endtask : t_reset
	task t_setup;
		foreach (tbl[k]) wr(tbl[k][23:8], tbl[k][7:0]);
		idle(4);
		chk("stable_o", 8'h01, {7'h0, stable_o});
		rd(16'h0D0C, 8'h80);
		rd(16'h0D0E, 8'h90);
	endtask : t_setup
	task t_monitor;
		wait_flt(0, 1'b0);
		wait_flt(3, 1'b0);
		idle(40);
		chk("faulted_o", 8'h04, {4'h0, faulted_o});
		chk("valid_o", 8'h00, {4'h0, valid_o});
		wr(16'h0A0E, 8'h05);
		idle(2);
		chk("valid_o", 8'h01, {4'h0, valid_o});
		rd(16'h0A0E, 8'h00);
		rd(16'h0D05, 8'h41);
	endtask : t_monitor
	task t_override;
		wr(16'h0A0F, 8'h01);
		idle(2);
		chk("faulted_o", 8'h05, {4'h0, faulted_o});
		chk("valid_o", 8'h00, {4'h0, valid_o});
		wr(16'h0A0F, 8'h00);
		wait_flt(0, 1'b0);
		idle(20);
		chk("valid_o", 8'h00, {4'h0, valid_o});
		wr(16'h0A10, 8'h04);
		idle(2);
		chk("faulted_o", 8'h00, {4'h0, faulted_o});
		wr(16'h0A0F, 8'h04);
		idle(2);
		chk("faulted_o", 8'h04, {4'h0, faulted_o});
		wr(16'h0A10, 8'h00);
		wr(16'h0A0F, 8'h00);
	endtask : t_override
	task t_slow;
		slow[0] = 1'b1;
		wait_flt(0, 1'b1);
		slow[0] = 1'b0;
		wait_flt(0, 1'b0);
		run[1] = 1'b0;
		wait_flt(1, 1'b1);
		run[1] = 1'b1;
		wait_flt(1, 1'b0);
	endtask : t_slow
	task t_pair;
		wr(16'h0500, 8'h01);
		idle(3);
		chk("faulted_o", 8'h06, {4'h0, faulted_o});
		wr(16'h0500, 8'h00);
		wait_flt(1, 1'b0);
	endtask : t_pair
	task t_active;
		active_ref_en_i = 1'b1;
		active_ref_i = 2'd2;
		idle(3);
		chk("active_prof_o", 8'h01, {5'h0, active_prof_o});
		chk("active_prof_valid_o", 8'h01, {7'h0, active_prof_valid_o});
		// clock enable low must freeze the captured profile
		ce_i = 1'b0;
		active_ref_i = 2'd0;
		idle(3);
		chk("active_prof_o", 8'h01, {5'h0, active_prof_o});
		ce_i = 1'b1;
		idle(3);
		chk("active_prof_o", 8'h00, {5'h0, active_prof_o});
		active_ref_en_i = 1'b0;
	endtask : t_active
	task t_auto;
		wr(16'h0504, 8'h09);
		assign_we_i = 1'b1;
		assign_ref_i = 2'd3;
		assign_prof_i = 3'd5;
		@(negedge clk_i);
		assign_we_i = 1'b0;
		rd(16'h0D0F, 8'hD0);
		idle(60);
		rd(16'h0D0F, 8'hD0);
	endtask : t_auto
	// long sys period shortens the ms tick to under 60000 cycles; runs last
	task t_timers;
		int n;
		n = 0;
		wr(16'h0504, 8'h01);
		wr(16'h064E, 8'h01);
		wr(16'h060C, 8'h01);
		wr(16'h0A10, 8'h01);
		idle(2);
		chk("valid_o", 8'h00, {4'h0, valid_o});
		for (int k = 0; k < 3; k++) wr(16'(16'h0100 + k), 8'hFF);
		while (valid_o[0] !== 1'b1 && n < 62000) begin
			@(negedge clk_i);
			n++;
		end
		chk("valid_o", 8'h01, {4'h0, valid_o});
		idle(2);
		rd(16'h0D0E, 8'h10);
		rd(16'h0D0F, 8'hD0);
	endtask : t_timers
	// ********************
	// clock, watchdog, sequence
	// ********************
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		#400000;
		num_errors++;
		$display("unexpected watchdog expired");
		end_of_test();
	end
	initial begin
		{reset_n_i, reg_wr_i, reg_rd_i, assign_we_i, active_ref_en_i} = 5'h00;
		{reg_addr_i, reg_wdata_i, assign_ref_i, active_ref_i, assign_prof_i} = 31'h0;
		ce_i = 1'b1;
		run = 4'hF;
		slow = 4'h0;
		repeat (8) @(negedge clk_i);
		reset_n_i = 1'b1;
		t_reset();
		t_setup();
		t_monitor();
		t_override();
		t_slow();
		t_pair();
		t_active();
		t_auto();
		t_timers();
		end_of_test();
	end
endmodule : rvm_monitor_top_tb
